// *** core/sample_lsb_marker_and_bank_trim.sv ***
`timescale 1ns/1ps
// Operation
// - phase-0 trim drives bank 5 at 0 degrees
// - phase-90 trim drives bank 5 at -90 degrees
// - trims reset to factory value, read/write
// - marker enable puts marker in sample LSB
// - marker wins over calibration flag
// - marker delayed to match sample latency
// - 8-bit mode: marker in LSB, seven data
// - 12-bit mode: marker in LSB, eleven data
// - lane alignment control-bit count stays zero
module sample_lsb_marker_and_bank_trim
    import lsb_marker_pkg::*;
#(
    parameter logic [7:0] FACTORY_TRIM_PHASE0 = TRIM_FACTORY_DEFAULT,
    parameter logic [7:0] FACTORY_TRIM_PHASE90 = TRIM_FACTORY_DEFAULT,
    parameter int MARKER_DELAY = 4,
    parameter int BUFFER_DEPTH = 2
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter side
    input wire logic marker_pin,
    output logic marker_input_receiver_enable,
    input wire logic cal_state_flag,
    output logic [7:0] bank5_trim,
    output logic bank5_phase90,
    // sample stream into the transport layer
    input wire logic in_valid,
    output logic in_ready,
    input sample_s in_sample,
    output logic out_valid,
    input wire logic out_ready,
    output sample_s out_sample,
    output logic [1:0] ila_cs_field
);

    // =====================================================================
    // register storage
    logic [7:0] trim_phase0_reg;
    logic [7:0] trim_phase90_reg;
    logic [7:0] lsb_control_reg;
    logic [7:0] core_config_reg;
    logic [31:0] prdata_reg;
    logic [7:0] bank5_trim_reg;
    logic bank5_phase90_reg;
    logic marker_seen_reg;
    logic [1:0] ila_cs_reg;

    // =====================================================================
    // apb decode
    wire [ADDR_W-3:0] reg_index = paddr[ADDR_W-1:2];
    wire word_aligned = (paddr[1:0] == 2'h0);
    wire hit_trim0 = word_aligned && (reg_index == IDX_TRIM_PHASE0);
    wire hit_trim90 = word_aligned && (reg_index == IDX_TRIM_PHASE90);
    wire hit_lsb = word_aligned && (reg_index == IDX_LSB_CONTROL);
    wire hit_config = word_aligned && (reg_index == IDX_CORE_CONFIG);
    wire hit_status = word_aligned && (reg_index == IDX_CORE_STATUS);
    wire hit_any = hit_trim0 || hit_trim90 || hit_lsb || hit_config || hit_status;
    // apb phases; only the access cycle may change register state
    wire setup_phase = psel && !penable;
    wire access_phase = psel && penable;
    // status is read-only, so a write to it is reported as an error
    wire access_bad = !hit_any || (pwrite && hit_status);
    wire write_ok = access_phase && pwrite && !access_bad && pstrb[0];
    wire wr_trim0 = write_ok && hit_trim0;
    wire wr_trim90 = write_ok && hit_trim90;
    wire wr_lsb = write_ok && hit_lsb;
    wire wr_config = write_ok && hit_config;

    // zero wait states: every access completes in its first access cycle
    assign pready = access_phase;
    assign pslverr = access_phase && access_bad;
    assign prdata = prdata_reg;

    // =====================================================================
    // decoded configuration bits
    wire marker_en = lsb_control_reg[LSB_CTRL_MARKER_EN];
    wire phase90_sel = core_config_reg[CFG_PHASE90];
    wire cal_flag_en = core_config_reg[CFG_CAL_FLAG_EN];
    wire mode_8bit = core_config_reg[CFG_MODE_8BIT];
    wire marker_rx_en = core_config_reg[CFG_MARKER_RX_EN];
    wire ddc_bypass = core_config_reg[CFG_DDC_BYPASS];
    // the block does not refuse an unsupported combination; it only flags it
    wire marker_bad_mode = marker_en && !ddc_bypass;
    wire marker_no_rx = marker_en && !marker_rx_en;

    // status word: sticky seen flag, two misuse flags, then what the bank really gets
    wire [31:0] status_word = {
        20'h0,
        marker_seen_reg,
        marker_no_rx,
        marker_bad_mode,
        bank5_phase90_reg,
        bank5_trim_reg
    };

    // read mux, idle value zero; reserved bits above the 8-bit fields read zero
    wire [31:0] read_word =
        hit_trim0 ? {24'h0, trim_phase0_reg} :
        hit_trim90 ? {24'h0, trim_phase90_reg} :
        hit_lsb ? {24'h0, lsb_control_reg} :
        hit_config ? {24'h0, core_config_reg} :
        hit_status ? status_word : 32'h0;

    // =====================================================================
    // trim registers come up holding the factory value and stay writable
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            trim_phase0_reg <= FACTORY_TRIM_PHASE0;
            trim_phase90_reg <= FACTORY_TRIM_PHASE90;
        end
        else
        begin
            if (wr_trim0)
                trim_phase0_reg <= pwdata[7:0];
            if (wr_trim90)
                trim_phase90_reg <= pwdata[7:0];
        end
    end

    // control and configuration registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            lsb_control_reg <= LSB_CONTROL_RESET;
            core_config_reg <= CORE_CONFIG_RESET;
        end
        else
        begin
            if (wr_lsb)
                lsb_control_reg <= pwdata[7:0];
            if (wr_config)
                core_config_reg <= pwdata[7:0];
        end
    end

    // read data is captured in the setup cycle and held through the access
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            prdata_reg <= 32'h0;
        else if (setup_phase && !pwrite)
            prdata_reg <= read_word;
    end

    // =====================================================================
    // bank 5 trim selection: only the value for the active clock phase is applied
    wire [7:0] trim_applied = phase90_sel ? trim_phase90_reg : trim_phase0_reg;

    // registered so a phase change and its trim reach the bank on the same edge
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            bank5_trim_reg <= FACTORY_TRIM_PHASE0;
            bank5_phase90_reg <= 1'b0;
        end
        else
        begin
            bank5_trim_reg <= trim_applied;
            bank5_phase90_reg <= phase90_sel;
        end
    end

    // converter-side controls leave from flip-flops, never from the decode
    assign bank5_trim = bank5_trim_reg;
    assign bank5_phase90 = bank5_phase90_reg;
    assign marker_input_receiver_enable = marker_rx_en;

    // =====================================================================
    // marker input: two-stage synchroniser, then a delay line
    logic marker_meta_reg;
    logic marker_sync_reg;
    logic [MARKER_DELAY-1:0] marker_delay_reg;

    // a disabled receiver delivers a quiet low, never a floating pin level
    wire marker_gated = marker_sync_reg && marker_rx_en;

    // only the second stage is read; the first may still be settling
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            marker_meta_reg <= 1'b0;
            marker_sync_reg <= 1'b0;
        end
        else
        begin
            marker_meta_reg <= marker_pin;
            marker_sync_reg <= marker_meta_reg;
        end
    end

    // the delay line runs every cycle like the sampling path it must track;
    // MARKER_DELAY is set to the sample path latency minus the synchroniser
    generate
        if (MARKER_DELAY > 1)
        begin : g_delay_long
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                    marker_delay_reg <= '0;
                else
                    marker_delay_reg <= {marker_delay_reg[MARKER_DELAY-2:0], marker_gated};
            end
        end
        else
        begin : g_delay_one
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                    marker_delay_reg <= '0;
                else
                    marker_delay_reg <= marker_gated;
            end
        end
    endgenerate

    // last tap: the marker that belongs to the sample accepted now
    wire marker_aligned = marker_delay_reg[MARKER_DELAY-1];

    // sticky seen flag, cleared by a write to the lsb control register with pstrb[0] set;
    // an arriving marker in the same cycle wins over that clear
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            marker_seen_reg <= 1'b0;
        else if (marker_aligned && marker_en)
            marker_seen_reg <= 1'b1;
        else if (wr_lsb)
            marker_seen_reg <= 1'b0;
    end

    // =====================================================================
    // buffer between the sampling path and the transport layer
    tagged_sample_s buf_in;
    tagged_sample_s buf_out;
    logic buf_out_valid;
    logic buf_out_ready;
    logic out_valid_reg;
    sample_s out_sample_reg;

    // marker and flag are tagged at acceptance, so a later stall keeps them aligned
    assign buf_in.data = in_sample.data;
    assign buf_in.marker = marker_aligned;
    assign buf_in.cal_flag = cal_state_flag;

    // the tag bits travel with their sample through the buffer
    sample_skid_buffer #(
        .WIDTH($bits(tagged_sample_s)),
        .DEPTH(BUFFER_DEPTH)
    ) i_sample_skid_buffer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(buf_in),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out)
    );

    // =====================================================================
    // choice of what the LSB carries; marker has priority over the flag
    lsb_source_e lsb_source;
    assign lsb_source = marker_en ? LSB_MARKER :
        cal_flag_en ? LSB_CAL_FLAG : LSB_DATA;

    // formatting uses the live configuration; change it only with the stream drained
    logic lsb_bit;
    logic [SAMPLE_W-1:0] formatted;

    // 8-bit samples sit in the low byte; the lost bits are the low four
    always_comb
    begin
        lsb_bit = 1'b0;
        formatted = buf_out.data;
        case (lsb_source)
            LSB_MARKER: lsb_bit = buf_out.marker;
            LSB_CAL_FLAG: lsb_bit = buf_out.cal_flag;
            LSB_DATA: lsb_bit = mode_8bit ? buf_out.data[4] : buf_out.data[0];
            default: lsb_bit = 1'b0;
        endcase
        if (mode_8bit)
            formatted = {4'h0, buf_out.data[SAMPLE_W-1:5], lsb_bit};
        else
            formatted = {buf_out.data[SAMPLE_W-1:1], lsb_bit};
    end

    // output stage register; it refills in the same cycle it is drained
    assign buf_out_ready = !out_valid_reg || out_ready;

    // output register holds its word for as long as the transport layer stalls
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            out_valid_reg <= 1'b0;
            out_sample_reg <= '0;
        end
        else if (buf_out_ready)
        begin
            out_valid_reg <= buf_out_valid;
            if (buf_out_valid)
                out_sample_reg.data <= formatted;
        end
    end

    // the transport side sees only registered valid and data
    assign out_valid = out_valid_reg;
    assign out_sample = out_sample_reg;

    // =====================================================================
    // lane alignment control-bit count is never raised by the inserted bit
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            ila_cs_reg <= ILA_CS_VALUE;
        else
            ila_cs_reg <= ILA_CS_VALUE;
    end

    // constant field, but registered like the rest of the alignment data
    assign ila_cs_field = ila_cs_reg;

endmodule

// *** core/lsb_marker_pkg.sv ***
package lsb_marker_pkg;

    // =====================================================================
    // register map (printed offsets are register indices, byte address = 4 * index)
    localparam logic [11:0] IDX_TRIM_PHASE0 = 12'h152;
    localparam logic [11:0] IDX_TRIM_PHASE90 = 12'h153;
    localparam logic [11:0] IDX_LSB_CONTROL = 12'h160;
    localparam logic [11:0] IDX_CORE_CONFIG = 12'h1f0;
    localparam logic [11:0] IDX_CORE_STATUS = 12'h1f1;
    localparam int ADDR_W = 14;

    // =====================================================================
    // field positions
    localparam int LSB_CTRL_MARKER_EN = 0;
    localparam int CFG_PHASE90 = 0;
    localparam int CFG_CAL_FLAG_EN = 1;
    localparam int CFG_MODE_8BIT = 2;
    localparam int CFG_MARKER_RX_EN = 3;
    localparam int CFG_DDC_BYPASS = 4;
    localparam int STAT_TRIM_LSB = 0;
    localparam int STAT_PHASE90 = 8;
    localparam int STAT_MARKER_BAD_MODE = 9;
    localparam int STAT_MARKER_NO_RX = 10;
    localparam int STAT_MARKER_SEEN = 11;

    // =====================================================================
    // reset values
    localparam logic [7:0] LSB_CONTROL_RESET = 8'h00;
    localparam logic [7:0] CORE_CONFIG_RESET = 8'h10;
    localparam logic [7:0] TRIM_FACTORY_DEFAULT = 8'h80;
    localparam logic [1:0] ILA_CS_VALUE = 2'h0;

    // =====================================================================
    // sample carriers
    localparam int SAMPLE_W = 12;

    typedef struct packed {
        logic [SAMPLE_W-1:0] data;
    } sample_s;

    typedef struct packed {
        logic [SAMPLE_W-1:0] data;
        logic marker;
        logic cal_flag;
    } tagged_sample_s;

    typedef enum logic [1:0] {
        LSB_DATA,
        LSB_MARKER,
        LSB_CAL_FLAG
    } lsb_source_e;

endpackage

// *** core/sample_skid_buffer.sv ***
`timescale 1ns/1ps
// two-entry buffer; a stall on the drain side propagates back as in_ready low
module sample_skid_buffer
    import lsb_marker_pkg::*;
#(
    parameter int WIDTH = 14,
    parameter int DEPTH = 2
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] DEPTH_C = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_C = (PTR_W)'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // =====================================================================
    // flags come straight from the occupancy count, so full and empty are exact
    assign in_ready = (count_reg != DEPTH_C);
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];

    // storage entries, written only at the write pointer
    generate
        for (genvar i = 0; i < DEPTH; i++)
        begin : g_entry
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                    mem_reg[i] <= '0;
                else if (push && wr_ptr_reg == (PTR_W)'(i))
                    mem_reg[i] <= in_data;
            end
        end
    endgenerate

    // pointers and count
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == LAST_C) ? '0 : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == LAST_C) ? '0 : rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end

endmodule

// *** sim/lsb_marker_props.sv ***
`timescale 1ns/1ps
// =====================================================================
// port-level checks for the marker and trim block
module lsb_marker_props
    import lsb_marker_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire sample_s out_sample,
    input wire logic [1:0] ila_cs_field,
    input wire logic bank5_phase90,
    input wire logic marker_input_receiver_enable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // a write to the core configuration word that really lands
    wire wr_cfg = psel && penable && pwrite && pstrb[0] && paddr == 14'h07c0;

    chk_zero_wait: assert property (psel && penable |-> pready)
        else $error("access cycle without ready");
    chk_idle_quiet: assert property (!psel |-> !pready && !pslverr)
        else $error("answer while not selected");
    chk_unmapped_err: assert property (psel && penable && paddr == 14'h0004 |-> pslverr)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (psel && penable && paddr == 14'h0548 |-> !pslverr)
        else $error("trim access refused");
    chk_cs_zero: assert property (ila_cs_field == 2'h0)
        else $error("control bit count not zero");
    chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample))
        else $error("output sample changed while stalled");
    chk_drop_handshake: assert property ($fell(out_valid) |-> $past(out_ready))
        else $error("output valid dropped without handshake");
    chk_phase_copy: assert property (wr_cfg |=> ##1 bank5_phase90 == $past(pwdata[0], 2))
        else $error("phase select not applied");
    chk_rx_copy: assert property (wr_cfg |=> marker_input_receiver_enable == $past(pwdata[3]))
        else $error("receiver enable not following config");
endmodule

bind sample_lsb_marker_and_bank_trim lsb_marker_props i_lsb_marker_props (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .out_valid(out_valid), .out_ready(out_ready), .out_sample(out_sample),
    .ila_cs_field(ila_cs_field), .bank5_phase90(bank5_phase90),
    .marker_input_receiver_enable(marker_input_receiver_enable));

// *** sim/sample_sink_model.sv ***
`timescale 1ns/1ps
// =====================================================================
// transport-side sink: stalls at random, or fully while stall is high
module sample_sink_model
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic stall,
    output logic out_ready
);
    // random ready keeps the skid buffer busy in both directions
    always @(posedge core_clk)
        if (!rst_n)
            out_ready <= 1'b0;
        else
            out_ready <= !stall && ($urandom_range(3) != 0);
endmodule

// *** sim/sample_lsb_marker_and_bank_trim_tb.sv ***
`timescale 1ns/1ps
module sample_lsb_marker_and_bank_trim_tb;
    import lsb_marker_pkg::*;
    // =====================================================================
    // stimulus and observation
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 14'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic marker_pin = 1'b0;
    logic cal_state_flag = 1'b0;
    logic in_valid = 1'b0;
    logic stall = 1'b0;
    sample_s in_sample = 12'h0;
    sample_s out_sample;
    logic [31:0] prdata;
    logic pready, pslverr, rx_en, bank5_phase90, in_ready, out_valid, out_ready;
    logic [7:0] bank5_trim;
    logic [1:0] ila_cs_field;
    int err_count = 0;
    int samples_checked = 0;
    logic [11:0] exp_q[$];
    logic mk_en = 1'b0;
    logic cal_en = 1'b0;
    logic m8 = 1'b0;

    always #50 core_clk = ~core_clk;

    sample_lsb_marker_and_bank_trim i_sample_lsb_marker_and_bank_trim (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .marker_pin(marker_pin), .marker_input_receiver_enable(rx_en),
        .cal_state_flag(cal_state_flag), .bank5_trim(bank5_trim), .bank5_phase90(bank5_phase90),
        .in_valid(in_valid), .in_ready(in_ready), .in_sample(in_sample), .out_valid(out_valid),
        .out_ready(out_ready), .out_sample(out_sample), .ila_cs_field(ila_cs_field));

    sample_sink_model i_sample_sink_model (
        .core_clk(core_clk), .rst_n(rst_n), .stall(stall), .out_ready(out_ready));

    // =====================================================================
    // helpers
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task end_sim;
        $display("checked=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one apb transfer; entered and left just after a rising edge
    task apb(input logic w, input logic [11:0] idx, input logic [7:0] d, input logic [31:0] er, input logic ee);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, d};
        pstrb <= 4'hf;
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1 && ++n < 20);
        if (n >= 20)
        begin
            err_count++;
            end_sim();
        end
        if (!w)
            check(prdata, er);
        check({31'h0, pslverr}, {31'h0, ee});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk); // the next call never re-drives psel in this step
    endtask

    // expected word on the transport side for one accepted sample
    function logic [11:0] expect_of(input logic [11:0] d, input logic c);
        logic b;
        b = mk_en ? marker_pin : (cal_en ? c : (m8 ? d[4] : d[0]));
        return m8 ? {4'h0, d[11:5], b} : {d[11:1], b};
    endfunction

    // ready is taken at the rising edge, before the buffer's own update lands
    task send(input logic [11:0] d, input int bound, output logic ok);
        int n;
        logic c;
        c = 1'($urandom);
        n = 0;
        ok = 1'b0;
        in_valid <= 1'b1;
        in_sample <= d;
        cal_state_flag <= c;
        while (!ok && n < bound)
        begin
            @(posedge core_clk);
            n++;
            ok = (in_ready === 1'b1);
        end
        if (ok)
            exp_q.push_back(expect_of(d, c));
        else
            in_valid <= 1'b0;
    endtask

    task drain;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 300)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 300)
        begin
            err_count++;
            end_sim();
        end
    endtask

    // =====================================================================
    // scoreboard: oldest note against each delivered sample
    always @(posedge core_clk)
        if (rst_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1)
        begin
            if (exp_q.size() == 0)
                check({20'h0, out_sample.data}, 32'hffffffff);
            else
                check({20'h0, out_sample.data}, {20'h0, exp_q.pop_front()});
        end

    // =====================================================================
    // main sequence
    initial
    begin
        logic ok;
        logic [7:0] t0;
        logic [7:0] t1;
        int n;
        void'($urandom(32));
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, IDX_TRIM_PHASE0, 8'h0, {24'h0, TRIM_FACTORY_DEFAULT}, 1'b0);
        apb(1'b0, IDX_TRIM_PHASE90, 8'h0, {24'h0, TRIM_FACTORY_DEFAULT}, 1'b0);
        apb(1'b0, IDX_LSB_CONTROL, 8'h0, {24'h0, LSB_CONTROL_RESET}, 1'b0);
        apb(1'b0, IDX_CORE_CONFIG, 8'h0, {24'h0, CORE_CONFIG_RESET}, 1'b0);
        apb(1'b0, 12'h001, 8'h0, 32'h0, 1'b1);
        check({24'h0, bank5_trim}, {24'h0, TRIM_FACTORY_DEFAULT});
        t0 = 8'($urandom);
        t1 = ~t0;
        apb(1'b1, IDX_TRIM_PHASE0, t0, 32'h0, 1'b0);
        apb(1'b1, IDX_TRIM_PHASE90, t1, 32'h0, 1'b0);
        apb(1'b0, IDX_TRIM_PHASE0, 8'h0, {24'h0, t0}, 1'b0);
        apb(1'b0, IDX_TRIM_PHASE90, 8'h0, {24'h0, t1}, 1'b0);
        repeat (2) @(posedge core_clk);
        check({24'h0, bank5_trim}, {24'h0, t0});
        apb(1'b1, IDX_CORE_CONFIG, 8'h11, 32'h0, 1'b0);
        repeat (2) @(posedge core_clk);
        check({24'h0, bank5_trim}, {24'h0, t1});
        apb(1'b0, IDX_CORE_STATUS, 8'h0, {23'h0, 1'b1, t1}, 1'b0);
        apb(1'b1, IDX_CORE_CONFIG, 8'h10, 32'h0, 1'b0);
        repeat (2) @(posedge core_clk);
        check({24'h0, bank5_trim}, {24'h0, t0});
        apb(1'b0, IDX_CORE_STATUS, 8'h0, {24'h0, t0}, 1'b0);
        apb(1'b1, IDX_CORE_STATUS, 8'h0, 32'h0, 1'b1);
        // every mix of marker, flag and width; decimation stays bypassed
        for (int m = 0; m < 8; m++)
        begin
            mk_en = m[0];
            cal_en = m[1];
            m8 = m[2];
            apb(1'b1, IDX_CORE_CONFIG, {3'h0, 1'b1, mk_en, m8, cal_en, 1'b0}, 32'h0, 1'b0);
            apb(1'b1, IDX_LSB_CONTROL, {7'h0, mk_en}, 32'h0, 1'b0);
            marker_pin <= m[1]; // marker high in one 12-bit and one 8-bit marker mode
            repeat (12) @(posedge core_clk);
            repeat (12)
            begin
                send(12'($urandom), 20, ok);
                check({31'h0, ok}, 32'h1);
            end
            in_valid <= 1'b0;
            drain();
        end
        apb(1'b0, IDX_CORE_STATUS, 8'h0, {20'h0, 4'h8, t0}, 1'b0);
        // a stalled sink must make the buffer refuse, then give every word back
        stall <= 1'b1;
        repeat (2) @(posedge core_clk);
        n = 0;
        ok = 1'b1;
        while (ok && n < 8)
        begin
            send(12'($urandom), 3, ok);
            n++;
        end
        if (ok)
            in_valid <= 1'b0;
        check(32'(n > 2 && ok == 1'b0), 32'h1);
        stall <= 1'b0;
        drain();
        end_sim();
    end
endmodule
